// File: message_unit_queues.sv
// message unit: host list ports, queue pointers, counts and interrupts
`timescale 1ns/1ps
module message_unit_queues
  import msg_queue_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // host target side, same clock
  input wire logic host_req_i,
  input wire logic host_we_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [31:0] host_wdata_i,
  input wire logic host_wr_pending_i,
  output logic host_busy_o,
  output logic host_ack_o,
  output logic [31:0] host_rdata_o,
  // local processor registers
  input wire logic lp_req_i,
  input wire logic lp_we_i,
  input wire logic [7:0] lp_addr_i,
  input wire logic [31:0] lp_wdata_i,
  output logic lp_ack_o,
  output logic [31:0] lp_rdata_o,
  // local memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_done_i,
  input wire logic [31:0] mem_rdata_i,
  // interrupts
  output logic proc_irq_o,
  output logic proc_fiq_o,
  output logic pci_irq_n_o
);
  host_state_t state_reg;
  logic busy_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [31:0] mem_addr_reg;
  logic [31:0] mem_wdata_reg;
  logic is_outbound_reg;
  logic [31:0] ctrl_reg;
  logic [1:0] irq_mask_reg;
  logic ob_mask_reg;
  logic [CNT_W-1:0] ib_free_cnt_reg;
  logic [CNT_W-1:0] ib_post_cnt_reg;
  logic [CNT_W-1:0] ob_post_cnt_reg;
  logic lp_ack_reg;
  logic [31:0] lp_rdata_reg;
  logic proc_irq_reg;
  logic proc_fiq_reg;
  logic pci_irq_n_reg;
  logic [QSIZE_W-1:0] qsize;
  logic [31:0] ib_free_head;
  logic [31:0] ib_post_tail;
  logic [31:0] ob_free_tail;
  logic [31:0] ob_post_head;
  logic lp_wr;
  logic mem_fin;
  logic adv_ib_free;
  logic adv_ib_post;
  logic adv_ob_free;
  logic adv_ob_post;
  logic take;

  function automatic logic lp_hit(input logic [7:0] off);
    lp_hit = lp_wr && (lp_addr_i == off);
  endfunction

  assign lp_wr = lp_req_i && lp_we_i;
  assign take = host_req_i && !busy_reg;
  assign mem_fin = (state_reg == ST_MEM) && mem_done_i;
  assign qsize = ctrl_reg[QSIZE_MSB:QSIZE_LSB];
  // one advance per completed memory access
  assign adv_ib_free = mem_fin && !mem_we_reg && !is_outbound_reg;
  assign adv_ib_post = mem_fin && mem_we_reg && !is_outbound_reg;
  assign adv_ob_post = mem_fin && !mem_we_reg && is_outbound_reg;
  assign adv_ob_free = mem_fin && mem_we_reg && is_outbound_reg;

  // the four hardware-held pointers; software loads them at setup
  queue_pointer u_ib_free_head (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .load_i(lp_hit(LP_IB_FREE_HEAD)),
    .load_val_i(lp_wdata_i),
    .adv_i(adv_ib_free),
    .size_i(qsize),
    .ptr_o(ib_free_head)
  );
  queue_pointer u_ib_post_tail (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .load_i(lp_hit(LP_IB_POST_TAIL)),
    .load_val_i(lp_wdata_i),
    .adv_i(adv_ib_post),
    .size_i(qsize),
    .ptr_o(ib_post_tail)
  );
  queue_pointer u_ob_free_tail (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .load_i(lp_hit(LP_OB_FREE_TAIL)),
    .load_val_i(lp_wdata_i),
    .adv_i(adv_ob_free),
    .size_i(qsize),
    .ptr_o(ob_free_tail)
  );
  queue_pointer u_ob_post_head (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .load_i(lp_hit(LP_OB_POST_HEAD)),
    .load_val_i(lp_wdata_i),
    .adv_i(adv_ob_post),
    .size_i(qsize),
    .ptr_o(ob_post_head)
  );

  // host port sequencer; one request at a time, later ones refused while busy
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= ZERO_WORD;
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= ZERO_WORD;
      mem_wdata_reg <= ZERO_WORD;
      is_outbound_reg <= 1'b0;
    end else begin
      ack_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            busy_reg <= 1'b1;
            mem_we_reg <= host_we_i;
            mem_wdata_reg <= host_wdata_i;
            is_outbound_reg <= (host_addr_i == OUTBOUND_LIST_PORT);
            // decode of the two list ports
            if (host_addr_i == INBOUND_LIST_PORT) begin
              if (host_we_i) begin
                mem_addr_reg <= ib_post_tail;
                state_reg <= ST_ORDER;
              end else if (ib_free_cnt_reg == '0) begin
                // empty free queue answers with the invalid entry
                rdata_reg <= FRAME_INVALID;
                state_reg <= ST_RESP;
              end else begin
                mem_addr_reg <= ib_free_head;
                mem_req_reg <= 1'b1;
                state_reg <= ST_MEM;
              end
            end else if (host_addr_i == OUTBOUND_LIST_PORT) begin
              if (host_we_i) begin
                mem_addr_reg <= ob_free_tail;
                mem_req_reg <= 1'b1;
                state_reg <= ST_MEM;
              end else if (ob_post_cnt_reg == '0) begin
                rdata_reg <= FRAME_INVALID;
                state_reg <= ST_RESP;
              end else begin
                mem_addr_reg <= ob_post_head;
                mem_req_reg <= 1'b1;
                state_reg <= ST_MEM;
              end
            end else begin
              // unmapped offsets read zero, writes dropped
              rdata_reg <= ZERO_WORD;
              state_reg <= ST_RESP;
            end
          end
        end
        ST_ORDER: begin
          // post only after earlier host writes reached memory
          if (!host_wr_pending_i) begin
            mem_req_reg <= 1'b1;
            state_reg <= ST_MEM;
          end
        end
        ST_MEM: begin
          // host held until the single word access completes
          if (mem_done_i) begin
            mem_req_reg <= 1'b0;
            rdata_reg <= mem_we_reg ? ZERO_WORD : mem_rdata_i;
            state_reg <= ST_RESP;
          end
        end
        ST_RESP: begin
          ack_reg <= 1'b1;
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // count registers; hardware and software events in one cycle both count
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ib_free_cnt_reg <= '0;
      ib_post_cnt_reg <= '0;
      ob_post_cnt_reg <= '0;
    end else begin
      // software write adds one free entry; host pop removes one
      ib_free_cnt_reg <= ib_free_cnt_reg
        + CNT_W'(lp_hit(LP_IB_FREE_CNT)) - CNT_W'(adv_ib_free);
      // host post adds one; software write removes one
      ib_post_cnt_reg <= ib_post_cnt_reg
        + CNT_W'(adv_ib_post) - CNT_W'(lp_hit(LP_IB_POST_CNT));
      // software write adds one; host pop removes one
      ob_post_cnt_reg <= ob_post_cnt_reg
        + CNT_W'(lp_hit(LP_OB_POST_CNT)) - CNT_W'(adv_ob_post);
    end
  end

  // control and mask registers
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= ZERO_WORD;
      irq_mask_reg <= 2'h0;
      ob_mask_reg <= 1'b0;
    end else begin
      if (lp_hit(LP_CTRL)) begin
        ctrl_reg <= lp_wdata_i;
      end
      if (lp_hit(LP_IRQ_MASK)) begin
        irq_mask_reg <= lp_wdata_i[IRQ_FAST_BIT:IRQ_NORMAL_BIT];
      end
      if (lp_hit(LP_OB_IRQ_MASK)) begin
        ob_mask_reg <= lp_wdata_i[OB_MASK_BIT];
      end
    end
  end

  // local register reads, answered one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      lp_ack_reg <= 1'b0;
      lp_rdata_reg <= ZERO_WORD;
    end else begin
      lp_ack_reg <= lp_req_i;
      if (lp_req_i && !lp_we_i) begin
        if (lp_addr_i == LP_CTRL) begin
          lp_rdata_reg <= ctrl_reg;
        end else if (lp_addr_i == LP_IB_FREE_HEAD) begin
          lp_rdata_reg <= ib_free_head;
        end else if (lp_addr_i == LP_IB_POST_TAIL) begin
          lp_rdata_reg <= ib_post_tail;
        end else if (lp_addr_i == LP_OB_FREE_TAIL) begin
          lp_rdata_reg <= ob_free_tail;
        end else if (lp_addr_i == LP_OB_POST_HEAD) begin
          lp_rdata_reg <= ob_post_head;
        end else if (lp_addr_i == LP_IB_FREE_CNT) begin
          lp_rdata_reg <= 32'(ib_free_cnt_reg);
        end else if (lp_addr_i == LP_IB_POST_CNT) begin
          lp_rdata_reg <= 32'(ib_post_cnt_reg);
        end else if (lp_addr_i == LP_OB_POST_CNT) begin
          lp_rdata_reg <= 32'(ob_post_cnt_reg);
        end else if (lp_addr_i == LP_IRQ_MASK) begin
          lp_rdata_reg <= 32'(irq_mask_reg);
        end else if (lp_addr_i == LP_OB_IRQ_MASK) begin
          lp_rdata_reg <= 32'(ob_mask_reg);
        end else begin
          lp_rdata_reg <= ZERO_WORD;
        end
      end
    end
  end

  // interrupts are levels on the counts, so they cannot lose a post
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      proc_irq_reg <= 1'b0;
      proc_fiq_reg <= 1'b0;
      pci_irq_n_reg <= 1'b1;
    end else begin
      // held while any inbound post is pending and its enable bit is set
      proc_irq_reg <= (ib_post_cnt_reg != '0) && irq_mask_reg[IRQ_NORMAL_BIT];
      proc_fiq_reg <= (ib_post_cnt_reg != '0) && irq_mask_reg[IRQ_FAST_BIT];
      // host interrupt while outbound posts remain, unless masked
      pci_irq_n_reg <= !((ob_post_cnt_reg != '0) && !ob_mask_reg);
    end
  end

  assign host_busy_o = busy_reg;
  assign host_ack_o = ack_reg;
  assign host_rdata_o = rdata_reg;
  assign mem_req_o = mem_req_reg;
  assign mem_we_o = mem_we_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign lp_ack_o = lp_ack_reg;
  assign lp_rdata_o = lp_rdata_reg;
  assign proc_irq_o = proc_irq_reg;
  assign proc_fiq_o = proc_fiq_reg;
  assign pci_irq_n_o = pci_irq_n_reg;
endmodule

// File: msg_queue_pkg.sv
// constants shared by the message unit queue logic
package msg_queue_pkg;
  // host-visible list ports, byte offsets from the first base address
  localparam logic [7:0] INBOUND_LIST_PORT = 8'h40;
  localparam logic [7:0] OUTBOUND_LIST_PORT = 8'h44;
  // local processor register offsets
  localparam logic [7:0] LP_CTRL = 8'h00;
  localparam logic [7:0] LP_IB_FREE_HEAD = 8'h04;
  localparam logic [7:0] LP_IB_POST_TAIL = 8'h08;
  localparam logic [7:0] LP_OB_FREE_TAIL = 8'h0c;
  localparam logic [7:0] LP_OB_POST_HEAD = 8'h10;
  localparam logic [7:0] LP_IB_FREE_CNT = 8'h14;
  localparam logic [7:0] LP_IB_POST_CNT = 8'h18;
  localparam logic [7:0] LP_OB_POST_CNT = 8'h1c;
  localparam logic [7:0] LP_IRQ_MASK = 8'h20;
  localparam logic [7:0] LP_OB_IRQ_MASK = 8'h24;
  // queue size field of the control register
  localparam int QSIZE_LSB = 10;
  localparam int QSIZE_MSB = 12;
  localparam int QSIZE_W = 3;
  // processor interrupt enable bits and the host interrupt mask bit
  localparam int IRQ_NORMAL_BIT = 0;
  localparam int IRQ_FAST_BIT = 1;
  localparam int OB_MASK_BIT = 0;
  // smallest queue, in entries; size field n gives this times 2**n
  localparam logic [31:0] Q_MIN_ENTRIES = 32'h0000_0010;
  // one entry is one 32-bit word
  localparam logic [31:0] ENTRY_BYTES = 32'h0000_0004;
  localparam int ENTRY_SHIFT = 2;
  // invalid frame pointer entry
  localparam logic [31:0] FRAME_INVALID = 32'hffff_ffff;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // host port sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ORDER = 2'b01,
    ST_MEM = 2'b10,
    ST_RESP = 2'b11
  } host_state_t;
endpackage

// File: queue_pointer.sv
// one hardware-held queue pointer with size-dependent wrap
`timescale 1ns/1ps
module queue_pointer
  import msg_queue_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  input wire logic adv_i,
  input wire logic [QSIZE_W-1:0] size_i,
  output logic [31:0] ptr_o
);
  logic [31:0] ptr_reg;
  logic [31:0] ptr_next;
  logic [31:0] wrap_mask;

  // byte span of the queue minus one; queue must be aligned to its span
  assign wrap_mask = ((Q_MIN_ENTRIES << size_i) << ENTRY_SHIFT) - 32'h0000_0001;

  always_comb begin
    ptr_next = ptr_reg;
    if (load_i) begin
      ptr_next = load_val_i;
    end else if (adv_i) begin
      ptr_next = (ptr_reg & ~wrap_mask) | ((ptr_reg + ENTRY_BYTES) & wrap_mask);
    end
  end

  // software load wins over an advance in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ptr_reg <= ZERO_WORD;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  assign ptr_o = ptr_reg;
endmodule

// File: mq_chk.sv
// checker: host port handshake, write ordering and interrupt levels
`timescale 1ns/1ps
module mq_chk
  import msg_queue_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic host_req_i,
  input wire logic host_we_i,
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_pending_i,
  input wire logic host_busy_o,
  input wire logic host_ack_o,
  input wire logic lp_req_i,
  input wire logic lp_we_i,
  input wire logic [7:0] lp_addr_i,
  input wire logic [31:0] lp_wdata_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_done_i,
  input wire logic proc_irq_o,
  input wire logic proc_fiq_o,
  input wire logic pci_irq_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] cur_addr;
  logic cur_we;
  logic [1:0] en_reg;
  logic mask_reg;
  int ib_cnt;
  int ob_cnt;
  wire lw = lp_req_i && lp_we_i;
  wire md = mem_req_o && mem_done_i;
  // wanted interrupt levels, one cycle ahead of the outputs
  wire irq_want = ib_cnt != 0 && en_reg[IRQ_NORMAL_BIT];
  wire fiq_want = ib_cnt != 0 && en_reg[IRQ_FAST_BIT];
  wire pci_want = ob_cnt != 0 && !mask_reg;
  // mirror counts and enables from port traffic, so levels can be judged
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cur_addr <= 8'h00;
      cur_we <= 1'h0;
      en_reg <= 2'h0;
      mask_reg <= 1'h0;
      ib_cnt <= 0;
      ob_cnt <= 0;
    end else begin
      if (host_req_i && !host_busy_o) begin
        cur_addr <= host_addr_i;
        cur_we <= host_we_i;
      end
      if (lw && lp_addr_i == LP_IRQ_MASK) en_reg <= lp_wdata_i[1:0];
      if (lw && lp_addr_i == LP_OB_IRQ_MASK) mask_reg <= lp_wdata_i[OB_MASK_BIT];
      ib_cnt <= ib_cnt + int'(md && cur_we && cur_addr == INBOUND_LIST_PORT)
        - int'(lw && lp_addr_i == LP_IB_POST_CNT);
      ob_cnt <= ob_cnt + int'(lw && lp_addr_i == LP_OB_POST_CNT)
        - int'(md && !cur_we && cur_addr == OUTBOUND_LIST_PORT);
    end
  end
  ack_pulse_a: assert property (host_ack_o |=> !host_ack_o)
    else $error("host ack wider than one cycle");
  ack_busy_a: assert property (host_ack_o |-> !host_busy_o && $past(host_busy_o))
    else $error("ack outside busy");
  take_busy_a: assert property (host_req_i && !host_busy_o |=> host_busy_o && !host_ack_o)
    else $error("taken request not busy");
  mem_hold_a: assert property (mem_req_o && !mem_done_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request dropped or changed");
  done_ack_a: assert property (md |=> !mem_req_o ##1 host_ack_o)
    else $error("ack not two cycles after memory done");
  post_order_a: assert property ($rose(mem_req_o) && cur_we &&
    cur_addr == INBOUND_LIST_PORT |-> !$past(host_wr_pending_i))
    else $error("post written while host writes pending");
  we_match_a: assert property ($rose(mem_req_o) |-> mem_we_o == cur_we)
    else $error("memory direction wrong");
  proc_irq_a: assert property (proc_irq_o == $past(irq_want))
    else $error("normal interrupt level wrong");
  proc_fiq_a: assert property (proc_fiq_o == $past(fiq_want))
    else $error("fast interrupt level wrong");
  pci_irq_a: assert property (pci_irq_n_o == !$past(pci_want))
    else $error("host interrupt level wrong");
endmodule

// File: mq_mem.sv
// local memory stand-in: word store answering after a settable delay
`timescale 1ns/1ps
module mq_mem
  import msg_queue_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wait_i,
  output logic done_o,
  output logic [31:0] rdata_o
);
  logic [31:0] store [logic [31:0]];
  logic [3:0] cnt = 4'h0;
  initial done_o = 1'h0;
  initial rdata_o = 32'h0;
  // one word access
  // data lines flip when not valid so stale values never pass as answers
  always @(posedge ref_clk_i) begin
    done_o <= 1'h0;
    rdata_o <= ~rdata_o;
    if (req_i && !done_o) begin
      if (cnt < wait_i) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        done_o <= 1'h1;
        if (we_i) store[addr_i] = wdata_i;
        else rdata_o <= store.exists(addr_i) ? store[addr_i] : FRAME_INVALID;
      end
    end
  end
endmodule

// File: testbench.sv
// self-checking bench for the message unit queue ports
`timescale 1ns/1ps
module testbench
  import msg_queue_pkg::*;
;
  localparam logic [32:0] NC = 33'h0;
  logic ref_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic host_req_i = 1'h0, host_we_i = 1'h0, host_wr_pending_i = 1'h0;
  logic lp_req_i = 1'h0, lp_we_i = 1'h0;
  logic [7:0] host_addr_i = 8'h00, lp_addr_i = 8'h00;
  logic [31:0] host_wdata_i = 32'h0, lp_wdata_i = 32'h0;
  logic host_busy_o, host_ack_o, lp_ack_o, mem_req_o, mem_we_o, mem_done_i;
  logic proc_irq_o, proc_fiq_o, pci_irq_n_o;
  logic [31:0] host_rdata_o, lp_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [3:0] mem_wait = 4'h0;
  logic [32:0] hq[$];
  logic [32:0] lq[$];
  int miscompares = 0;
  int tests_run = 0;
  integer seed = 56;
  always #5 ref_clk_i = ~ref_clk_i;
  message_unit_queues dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .host_req_i(host_req_i), .host_we_i(host_we_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_wr_pending_i(host_wr_pending_i),
    .host_busy_o(host_busy_o), .host_ack_o(host_ack_o), .host_rdata_o(host_rdata_o),
    .lp_req_i(lp_req_i), .lp_we_i(lp_we_i), .lp_addr_i(lp_addr_i),
    .lp_wdata_i(lp_wdata_i), .lp_ack_o(lp_ack_o), .lp_rdata_o(lp_rdata_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_done_i(mem_done_i), .mem_rdata_i(mem_rdata_i),
    .proc_irq_o(proc_irq_o), .proc_fiq_o(proc_fiq_o), .pci_irq_n_o(pci_irq_n_o));
  mq_mem mem (.ref_clk_i(ref_clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .wait_i(mem_wait),
    .done_o(mem_done_i), .rdata_o(mem_rdata_i));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    check(32'(hq.size() + lq.size()), 32'h0);
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // host port access; held data stays put until the next call
  task host(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] exp);
    while (host_busy_o !== 1'h0) @(negedge ref_clk_i);
    hq.push_back(exp);
    host_req_i = 1'h1;
    host_we_i = we;
    host_addr_i = a;
    host_wdata_i = d;
    @(negedge ref_clk_i);
    host_req_i = 1'h0;
    repeat (200) if (host_ack_o !== 1'h1) @(negedge ref_clk_i);
    check(32'(host_ack_o), 32'h1);
  endtask
  // local register access, answered in the following cycle
  task lp(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] exp);
    lq.push_back(exp);
    lp_req_i = 1'h1;
    lp_we_i = we;
    lp_addr_i = a;
    lp_wdata_i = d;
    @(negedge ref_clk_i);
    lp_req_i = 1'h0;
    @(negedge ref_clk_i);
  endtask
  // compare each completion with the oldest note when that note carries an expected value
  always @(negedge ref_clk_i) begin
    logic [32:0] e;
    if (host_ack_o === 1'h1) begin
      e = hq.pop_front();
      if (e[32]) check(host_rdata_o, e[31:0]);
    end
    if (lp_ack_o === 1'h1) begin
      e = lq.pop_front();
      if (e[32]) check(lp_rdata_o, e[31:0]);
    end
  end
  initial begin
    logic [31:0] v;
    repeat (4) @(negedge ref_clk_i);
    resetn_i = 1'h1;
    check(32'(pci_irq_n_o), 32'h1);
    lp(1'h1, LP_CTRL, 32'h0000_0400, NC);
    for (int i = 0; i < 4; i++) lp(1'h1, LP_IB_FREE_HEAD + 8'(4 * i), 32'h1000 * (i + 1), NC);
    lp(1'h1, LP_IRQ_MASK, 32'h3, NC);
    lp(1'h0, LP_CTRL, 32'h0, {1'h1, 32'h0000_0400});
    // empty lists answer the invalid entry and unmapped offsets answer zero, without touching memory
    host(1'h0, INBOUND_LIST_PORT, 32'h0, {1'h1, FRAME_INVALID});
    host(1'h0, OUTBOUND_LIST_PORT, 32'h0, {1'h1, FRAME_INVALID});
    host(1'h1, 8'h48, 32'h1, NC);
    host(1'h0, 8'h48, 32'h0, {1'h1, ZERO_WORD});
    $display("test empty lists done");
    for (int i = 0; i < 2; i++) begin
      mem.store[32'h1000 + 32'(4 * i)] = $random(seed);
      lp(1'h1, LP_IB_FREE_CNT, 32'h0, NC);
    end
    for (int i = 0; i < 2; i++) begin
      mem_wait = 4'($random(seed) & 7);
      host(1'h0, INBOUND_LIST_PORT, 32'h0, {1'h1, mem.store[32'h1000 + 32'(4 * i)]});
    end
    lp(1'h0, LP_IB_FREE_HEAD, 32'h0, {1'h1, 32'h0000_1008});
    lp(1'h0, LP_IB_FREE_CNT, 32'h0, {1'h1, ZERO_WORD});
    $display("test inbound pop done");
    // posts wait out earlier host writes still draining
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      host_wr_pending_i = 1'h1;
      fork
        begin
          repeat (6) @(negedge ref_clk_i);
          host_wr_pending_i = 1'h0;
        end
      join_none
      host(1'h1, INBOUND_LIST_PORT, v, NC);
      check(mem.store[32'h2000 + 32'(4 * i)], v);
      check(32'(proc_irq_o), 32'h1);
    end
    lp(1'h0, LP_IB_POST_CNT, 32'h0, {1'h1, 32'h0000_0002});
    lp(1'h0, LP_IB_POST_TAIL, 32'h0, {1'h1, 32'h0000_2008});
    lp(1'h1, LP_IRQ_MASK, 32'h2, NC);
    check(32'(proc_irq_o), 32'h0);
    lp(1'h1, LP_IB_POST_CNT, 32'h0, NC);
    check(32'(proc_fiq_o), 32'h1);
    lp(1'h1, LP_IB_POST_CNT, 32'h0, NC);
    check(32'(proc_fiq_o), 32'h0);
    $display("test inbound post done");
    v = $random(seed);
    mem.store[32'h4000] = v;
    lp(1'h1, LP_OB_POST_CNT, 32'h0, NC);
    check(32'(pci_irq_n_o), 32'h0);
    lp(1'h1, LP_OB_IRQ_MASK, 32'h1, NC);
    check(32'(pci_irq_n_o), 32'h1);
    lp(1'h1, LP_OB_IRQ_MASK, 32'h0, NC);
    host(1'h0, OUTBOUND_LIST_PORT, 32'h0, {1'h1, v});
    check(32'(pci_irq_n_o), 32'h1);
    lp(1'h0, LP_OB_POST_HEAD, 32'h0, {1'h1, 32'h0000_4004});
    lp(1'h0, LP_OB_POST_CNT, 32'h0, {1'h1, ZERO_WORD});
    $display("test outbound post done");
    // host fills all 32 free entries; the tail must come back to its base
    for (int i = 0; i < 32; i++) begin
      v = $random(seed);
      mem_wait = 4'($random(seed) & 3);
      host(1'h1, OUTBOUND_LIST_PORT, v, NC);
      check(mem.store[32'h3000 + 32'(4 * i)], v);
    end
    lp(1'h0, LP_OB_FREE_TAIL, 32'h0, {1'h1, 32'h0000_3000});
    repeat (2) @(negedge ref_clk_i);
    $display("test outbound free done");
    complete_run;
  end
  // the run needs under a thousand cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    complete_run;
  end
endmodule
bind message_unit_queues mq_chk chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .host_req_i(host_req_i), .host_we_i(host_we_i), .host_addr_i(host_addr_i),
  .host_wr_pending_i(host_wr_pending_i), .host_busy_o(host_busy_o),
  .host_ack_o(host_ack_o), .lp_req_i(lp_req_i), .lp_we_i(lp_we_i),
  .lp_addr_i(lp_addr_i), .lp_wdata_i(lp_wdata_i), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_done_i(mem_done_i),
  .proc_irq_o(proc_irq_o), .proc_fiq_o(proc_fiq_o), .pci_irq_n_o(pci_irq_n_o));
